// >>> logic/bcw_pkg.sv
/*
  Constants, field layout and register map for the boot configuration
  word one decoder.
  Assumes a single 100 MHz core clock and an active-low async reset.

  Notes on behaviour below.
*/
// Notes on behaviour
// RL1: Programmer writes ones to reserved bits 31-24 and 22-21.
// RL2: Force-enable bit 23 set runs the watchdog; software cannot disable it.
// RL3: Force-enable clear leaves watchdog off after reset; software may enable it.
// RL4: Postscale code n in bits 20-16 divides by two to the n.
// RL5: Postscale codes above 10100 act as 10100, maximum ratio.
// RL6: Switch/monitor field 1x blocks clock switching and fail-safe monitor.
// RL7: Switch/monitor field 01 allows switching, monitor stays off.
// RL8: Switch/monitor field 00 allows switching and runs the monitor.
// RL9: Programmer must not disable primary oscillator while it is selected.
// RL10: Word latched from storage at reset, read-only to software until next reset.
package bcw_pkg;
  // Register map (word offsets chosen for this block)
  localparam logic [3:0] BCW_ADDR_CFG_WORD   = 4'h0;
  localparam logic [3:0] BCW_ADDR_WDT_CTRL   = 4'h4;
  localparam logic [3:0] BCW_ADDR_STATUS     = 4'h8;
  // Field positions of the configuration word
  localparam int BCW_RSV_HI_MSB   = 31;
  localparam int BCW_RSV_HI_LSB   = 24;
  localparam int BCW_WDT_FORCE    = 23;
  localparam int BCW_RSV_MID_MSB  = 22;
  localparam int BCW_RSV_MID_LSB  = 21;
  localparam int BCW_WDTPS_MSB    = 20;
  localparam int BCW_WDTPS_LSB    = 16;
  localparam int BCW_CKSM_MSB     = 15;
  localparam int BCW_CKSM_LSB     = 14;
  localparam int BCW_PBDIV_MSB    = 13;
  localparam int BCW_PBDIV_LSB    = 12;
  localparam int BCW_CLKO_FUNC    = 10;
  localparam int BCW_POSC_MSB     = 9;
  localparam int BCW_POSC_LSB     = 8;
  localparam int BCW_TWO_SPEED    = 7;
  localparam int BCW_SOSC_EN      = 5;
  localparam int BCW_OSC_SEL_MSB  = 2;
  localparam int BCW_OSC_SEL_LSB  = 0;
  // Largest listed postscale code
  localparam logic [4:0] BCW_WDTPS_MAX     = 5'h14;
  // Reset values
  localparam logic [31:0] BCW_CFG_RST      = 32'hFFFF_FFFF;
  localparam logic        BCW_WDT_SW_RST   = 1'b0;
  localparam logic [31:0] BCW_RD_ZERO      = 32'h0000_0000;
  // Watchdog base tick period (arbitrary plain default) in ns, and cycles
  localparam int BCW_TICK_NS        = 1000;
  localparam int BCW_CLK_NS         = 10;
  localparam int BCW_TICK_CYC       = BCW_TICK_NS / BCW_CLK_NS;
  // Load sequence states, Gray coded
  typedef enum logic [1:0] {
    BCW_ST_RESET = 2'b00,
    BCW_ST_LOAD  = 2'b01,
    BCW_ST_RUN   = 2'b11
  } bcw_state_type;
endpackage

// >>> logic/bcw_wdt_div.sv
/*
  Watchdog postscaler: counts base ticks and pulses when 2^n ticks pass.
  Assumes the tick enable and code come from logic on the same clock.
*/
module bcw_wdt_div (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic       i_clear,
  input  wire logic [4:0] i_code,
  output logic            o_expire
);
  import bcw_pkg::*;

  logic [20:0] cnt_ff;
  logic [20:0] nxt_cnt;
  logic [20:0] limit;
  logic [4:0]  code_sat;
  logic        hit;

  // Out-of-range codes fold onto the largest listed ratio
  assign code_sat = (i_code > BCW_WDTPS_MAX) ? BCW_WDTPS_MAX : i_code; // [RL5]
  // Terminal count is 2^n - 1 ticks
  assign limit    = (21'h00_0001 << code_sat) - 21'h00_0001;           // [RL4]
  assign hit      = i_run && i_tick && (cnt_ff == limit);
  assign nxt_cnt  = (!i_run || i_clear || hit) ? 21'h00_0000 :
                    (i_tick ? cnt_ff + 21'h00_0001 : cnt_ff);

  // Counter; clear from software restarts the tick count, not the base tick already in progress
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff   <= 21'h00_0000;
      o_expire <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      o_expire <= hit && !i_clear;
    end
  end
endmodule

// >>> logic/bcw_top.sv
/*
  Boot configuration word one decoder: latches the nonvolatile word after
  reset, decodes watchdog, clock switching and oscillator policy, runs the
  watchdog postscaler, and serves a small read/write register port.
  Assumes the nonvolatile word is stable from two cycles before reset
  release until it is latched; it comes from outside this clock domain,
  so it passes two flip-flops before the latch reads it.
*/
// Implementation choices: the register offsets and the address-and-strobe port.
module bcw_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic [31:0] i_nv_cfg_word,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_cfg_valid,
  output logic             o_watchdog_running,
  output logic             o_watchdog_expire,
  output logic [4:0]       o_watchdog_postscale_code,
  output logic             o_clock_switch_allowed,
  output logic             o_fail_safe_monitor_on,
  output logic [1:0]       o_peripheral_bus_divider,
  output logic [1:0]       o_primary_oscillator_mode,
  output logic [2:0]       o_oscillator_select,
  output logic             o_two_speed_startup_enable,
  output logic             o_secondary_oscillator_enable,
  output logic             o_clock_out_pin_function,
  output logic             o_reserved_bits_bad
);
  import bcw_pkg::*;

  bcw_state_type state_ff;
  bcw_state_type nxt_state;
  logic [31:0]   cfg_ff;
  logic [31:0]   nv_meta_ff;
  logic [31:0]   nv_sync_ff;
  logic          wdt_sw_on_ff;
  logic [6:0]    tick_cnt_ff;
  logic          tick;
  logic          force_on;
  logic          wdt_run;
  logic          wr_ctrl;
  logic          wdt_clear;
  logic [1:0]    cksm;
  logic          loading;
  logic          rsv_bad;
  logic [31:0]   rd_mux;

  // Load sequence: on the second clock after release the word is captured, then frozen
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BCW_ST_RESET: nxt_state = BCW_ST_LOAD;
      BCW_ST_LOAD:  nxt_state = BCW_ST_RUN;
      BCW_ST_RUN:   nxt_state = BCW_ST_RUN;
      default:      nxt_state = BCW_ST_RESET;
    endcase
  end
  assign loading = (state_ff == BCW_ST_LOAD);

  // Two-stage capture of the strap; no reset, so it settles while reset is low
  always_ff @(posedge i_core_clk) begin
    nv_meta_ff <= i_nv_cfg_word;
    nv_sync_ff <= nv_meta_ff;
  end

  // Async reset loads a constant; the strap is caught by the second clock after release
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= BCW_ST_RESET;
      cfg_ff   <= BCW_CFG_RST;
    end else begin
      state_ff <= nxt_state;
      if (loading) begin
        cfg_ff <= nv_sync_ff; // [RL10]
      end
    end
  end

  // Field decode
  assign force_on = cfg_ff[BCW_WDT_FORCE];
  assign cksm     = cfg_ff[BCW_CKSM_MSB:BCW_CKSM_LSB];
  // Upper bit set wins whatever the lower bit says
  assign o_clock_switch_allowed = (state_ff == BCW_ST_RUN) && !cksm[1]; // [RL6] [RL7] [RL8]
  // Monitor only for code 00
  assign o_fail_safe_monitor_on = (state_ff == BCW_ST_RUN) && (cksm == 2'b00); // [RL6] [RL8]
  // Flag words not programmed with ones in reserved places
  assign rsv_bad = (cfg_ff[BCW_RSV_HI_MSB:BCW_RSV_HI_LSB] != 8'hFF) ||
                   (cfg_ff[BCW_RSV_MID_MSB:BCW_RSV_MID_LSB] != 2'b11); // [RL1]

  assign o_watchdog_postscale_code     = cfg_ff[BCW_WDTPS_MSB:BCW_WDTPS_LSB];
  assign o_peripheral_bus_divider      = cfg_ff[BCW_PBDIV_MSB:BCW_PBDIV_LSB];
  assign o_primary_oscillator_mode     = cfg_ff[BCW_POSC_MSB:BCW_POSC_LSB];
  assign o_oscillator_select           = cfg_ff[BCW_OSC_SEL_MSB:BCW_OSC_SEL_LSB];
  assign o_two_speed_startup_enable    = cfg_ff[BCW_TWO_SPEED];
  assign o_secondary_oscillator_enable = cfg_ff[BCW_SOSC_EN];
  assign o_clock_out_pin_function      = cfg_ff[BCW_CLKO_FUNC];
  assign o_cfg_valid                   = (state_ff == BCW_ST_RUN);
  assign o_reserved_bits_bad           = o_cfg_valid && rsv_bad;

  // Register port decode; the configuration word itself ignores writes
  assign wr_ctrl   = i_wr && (i_addr == BCW_ADDR_WDT_CTRL);
  assign wdt_clear = wr_ctrl && i_wdata[1];

  // Software watchdog enable: off after reset, may be set later
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wdt_sw_on_ff <= BCW_WDT_SW_RST; // [RL3]
    end else if (wr_ctrl) begin
      wdt_sw_on_ff <= i_wdata[0];     // [RL3]
    end
  end

  // Forced bit overrides any software attempt to stop the watchdog
  assign wdt_run = o_cfg_valid && (force_on || wdt_sw_on_ff); // [RL2] [RL3]
  assign o_watchdog_running = wdt_run;

  // Base tick divider; a pulse, not a second clock
  assign tick = (tick_cnt_ff == 7'(BCW_TICK_CYC - 1));
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_ff <= 7'h00;
    end else begin
      tick_cnt_ff <= tick ? 7'h00 : tick_cnt_ff + 7'h01;
    end
  end

  bcw_wdt_div u_wdt_div (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_run      (wdt_run),
    .i_tick     (tick),
    .i_clear    (wdt_clear),
    .i_code     (o_watchdog_postscale_code),
    .o_expire   (o_watchdog_expire)
  );

  // Read mux; unmapped addresses read zero
  assign rd_mux =
    (i_addr == BCW_ADDR_CFG_WORD) ? cfg_ff :
    (i_addr == BCW_ADDR_WDT_CTRL) ? {31'h0000_0000, wdt_sw_on_ff} :
    (i_addr == BCW_ADDR_STATUS)   ? {26'h000_0000, rsv_bad, o_fail_safe_monitor_on,
                                     o_clock_switch_allowed, force_on, wdt_run,
                                     o_cfg_valid} :
    BCW_RD_ZERO;

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= BCW_RD_ZERO;
    end else begin
      o_rdata <= i_rd ? rd_mux : BCW_RD_ZERO;
    end
  end
endmodule

// >>> tb/bcw_top_chk.sv
/*
  Port checker for the configuration word decoder.
  Assumes the word input only changes while reset is low.
*/
module bcw_chk
  import bcw_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rstn,
  input wire logic [31:0] i_nv_cfg_word,
  input wire logic [3:0]  i_addr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_cfg_valid,
  input wire logic        o_watchdog_running,
  input wire logic        o_watchdog_expire,
  input wire logic [4:0]  o_watchdog_postscale_code,
  input wire logic        o_clock_switch_allowed,
  input wire logic        o_fail_safe_monitor_on,
  input wire logic        o_reserved_bits_bad
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // Policy outputs track the latched word
  a_switch_policy: assert property (
    o_cfg_valid |-> o_clock_switch_allowed == !i_nv_cfg_word[15]) else $error("switch policy");
  a_monitor_policy: assert property (
    o_cfg_valid |-> o_fail_safe_monitor_on == (i_nv_cfg_word[15:14] == 2'b00))
    else $error("monitor policy");
  a_force_runs: assert property (
    o_cfg_valid && i_nv_cfg_word[23] |-> o_watchdog_running) else $error("forced dog off");
  a_off_at_load: assert property (
    $rose(o_cfg_valid) && !i_nv_cfg_word[23] |-> !o_watchdog_running) else $error("dog on");
  a_code_field: assert property (
    o_cfg_valid |-> o_watchdog_postscale_code == i_nv_cfg_word[20:16]) else $error("code");
  a_reserved_flag: assert property (
    o_cfg_valid |-> o_reserved_bits_bad == (i_nv_cfg_word[31:24] != 8'hFF
      || i_nv_cfg_word[22:21] != 2'b11)) else $error("reserved flag");
  // Read port: one cycle answer, zero otherwise
  a_cfg_readback: assert property (
    i_rd && i_addr == BCW_ADDR_CFG_WORD && o_cfg_valid |=> o_rdata == i_nv_cfg_word)
    else $error("word readback");
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0000_0000) else $error("rdata not idle");
  a_expire_pulse: assert property (
    o_watchdog_expire |=> !o_watchdog_expire [*8]) else $error("expire too long");
endmodule
bind bcw_top bcw_chk chk_u (.i_core_clk, .i_rstn, .i_nv_cfg_word, .i_addr, .i_rd, .o_rdata,
  .o_cfg_valid, .o_watchdog_running, .o_watchdog_expire, .o_watchdog_postscale_code,
  .o_clock_switch_allowed, .o_fail_safe_monitor_on, .o_reserved_bits_bad);

// >>> tb/testbench.sv
/*
  Self-checking bench for the configuration word decoder.
  Assumes a 100 MHz clock; the word changes only inside reset.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bcw_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [31:0] i_nv_cfg_word = 32'hFFFF_FFFF;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata, rd_val;
  logic        o_cfg_valid, o_watchdog_running, o_watchdog_expire, o_clock_switch_allowed;
  logic        o_fail_safe_monitor_on, o_reserved_bits_bad;
  logic [4:0]  o_watchdog_postscale_code;
  int          err_count = 0;
  int          n_checks = 0;
  int          g;
  // Rows: word, then {running, switch, monitor, reserved bad, code}
  logic [31:0] words [4] = '{32'hFFFF_FFFF, 32'hFF7F_7FFF, 32'hFF74_3FFF, 32'h00E0_BFFF};
  logic [8:0]  pol [4] = '{9'h11F, 9'h09F, 9'h0D4, 9'h120};
  bcw_top dut_u (.i_core_clk, .i_rstn, .i_nv_cfg_word, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_cfg_valid, .o_watchdog_running, .o_watchdog_expire,
    .o_watchdog_postscale_code, .o_clock_switch_allowed, .o_fail_safe_monitor_on,
    .o_peripheral_bus_divider(), .o_primary_oscillator_mode(), .o_oscillator_select(),
    .o_two_speed_startup_enable(), .o_secondary_oscillator_enable(),
    .o_clock_out_pin_function(), .o_reserved_bits_bad);
  // Free-running core clock
  always #5 i_core_clk = ~i_core_clk;
  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // Word is only sampled around reset, so each row needs its own boot
  task automatic boot(input logic [31:0] w);
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    i_nv_cfg_word <= w;
    repeat (5) @(posedge i_core_clk);
    #1;
    chk(32'(o_cfg_valid), 32'h0000_0000);
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
  endtask
  // Bounded wait for the next expire pulse
  task automatic wait_exp(output int gap);
    gap = 0;
    while (o_watchdog_expire !== 1'b1) begin
      @(posedge i_core_clk);
      #1;
      gap++;
      if (gap > 1000) begin
        err_count++;
        summarize();
      end
    end
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(words[i]);
      chk({23'h0, o_watchdog_running, o_clock_switch_allowed, o_fail_safe_monitor_on,
        o_reserved_bits_bad, o_watchdog_postscale_code}, {23'h0, pol[i]});
      rd(BCW_ADDR_CFG_WORD);
      chk(rd_val, words[i]);
      $display("row %0d done", i);
    end
    // Software enable, postscale 1:1 period, read-only word, unmapped, status
    boot(32'hFF60_7FFF);
    chk(32'(o_watchdog_running), 32'h0000_0000);
    wr(BCW_ADDR_WDT_CTRL, 32'h0000_0001);
    chk(32'(o_watchdog_running), 32'h0000_0001);
    wait_exp(g);
    @(posedge i_core_clk);
    #1;
    wait_exp(g);
    chk(32'(g + 1), 32'(BCW_TICK_CYC));
    wr(BCW_ADDR_CFG_WORD, 32'h0000_0000);
    rd(BCW_ADDR_CFG_WORD);
    chk(rd_val, 32'hFF60_7FFF);
    rd(4'hC);
    chk(rd_val, 32'h0000_0000);
    rd(BCW_ADDR_STATUS);
    chk(rd_val, 32'h0000_000B);
    $display("software enable test done");
    // Forced watchdog ignores a software disable; 1:4 ratio; clear restarts the count
    boot(32'hFFE2_FFFF);
    wr(BCW_ADDR_WDT_CTRL, 32'h0000_0000);
    chk(32'(o_watchdog_running), 32'h0000_0001);
    wait_exp(g);
    @(posedge i_core_clk);
    #1;
    wait_exp(g);
    chk(32'(g + 1), 32'(4 * BCW_TICK_CYC));
    repeat (150) @(posedge i_core_clk);
    wr(BCW_ADDR_WDT_CTRL, 32'h0000_0002);
    wait_exp(g);
    chk(32'(g), 32'(5 * BCW_TICK_CYC - 152));
    $display("forced watchdog test done");
    summarize();
  end
endmodule
